// *** hdl/twsp_pkg.sv ***
// Constants, register map and types for the three-wire serial port.
// Assumes an 8-bit register access port from the host core, same clock.
//
// What this block does
// - Enabled tx/rx mode: buffer write starts transfer
// - Buffer data loads shifter, shifts out
// - Shift register eight bits, read only
// - Receive mode: shifter read starts reception
// - Reception samples data input into shifter
// - Reset clears all five registers
// - Slave with select: start only select low
// - Enable clear resets flag and shifter
// - Mode bit: receive only or both
// - Receive only holds data output low
// - Select-use bit gates slave transfers
// - First-bit bit picks MSB or LSB
// - Status flag reads one while busy
// - Polarity and phase pick four types
// - Codes divide clock; code seven slave
// - Route bit moves clock, data-in pins
// - Pins free only when both registers zero
package twsp_pkg;
  localparam logic [15:0] TWSP_ADDR_INSW  = 16'hFF4F;
  localparam logic [15:0] TWSP_ADDR_MODE  = 16'hFF80;
  localparam logic [15:0] TWSP_ADDR_CLK   = 16'hFF81;
  localparam logic [15:0] TWSP_ADDR_TXBUF = 16'hFF82;
  localparam logic [15:0] TWSP_ADDR_SHIFT = 16'hFF83;
  localparam logic [7:0]  TWSP_RST_VAL    = 8'h00;
  localparam int          TWSP_BIT_EN     = 7;
  localparam int          TWSP_BIT_TRMD   = 6;
  localparam int          TWSP_BIT_SSE    = 5;
  localparam int          TWSP_BIT_DIR    = 4;
  localparam int          TWSP_BIT_ACT    = 0;
  localparam int          TWSP_BIT_CKP    = 4;
  localparam int          TWSP_BIT_DAP    = 3;
  localparam int          TWSP_BIT_ROUTE  = 2;
  localparam logic [7:0]  TWSP_MODE_WMASK = 8'hF0;
  localparam logic [7:0]  TWSP_CLK_WMASK  = 8'h1F;
  localparam logic [7:0]  TWSP_INSW_WMASK = 8'h07;
  localparam logic [2:0]  TWSP_CKS_SLAVE  = 3'h7;
  localparam logic [3:0]  TWSP_NBITS      = 4'h8;
  localparam int          TWSP_FIFO_DEPTH = 16;
  typedef enum logic [1:0] {
    TWSP_IDLE  = 2'b00,
    TWSP_LEAD  = 2'b01,
    TWSP_FIRST = 2'b10,
    TWSP_SECND = 2'b11
  } twsp_state_t;
endpackage : twsp_pkg

// *** hdl/twsp_fifo.sv ***
// Synchronous FIFO, flip-flop storage, valid/ready on both sides.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
module twsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : twsp_fifo

// *** hdl/twsp_top.sv ***
// Three-wire serial port: register access, clock/phase control, shifter.
// Assumes an 8-bit single-cycle register port; pins are outside clk domain.
`timescale 1ns/1ps
module twsp_top
  import twsp_pkg::*;
#(
  parameter int FIFO_DEPTH = TWSP_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  rx_pop_ready,
  output logic      [7:0]  rx_pop_data,
  output logic             rx_pop_valid,
  input  wire logic        sck_in_a,
  input  wire logic        sck_in_b,
  output logic             serial_clock_line_o,
  output logic             serial_clock_line_oe_n,
  input  wire logic        serial_data_in_a,
  input  wire logic        serial_data_in_b,
  output logic             serial_data_out,
  input  wire logic        slave_select_in_n,
  output logic             pins_port_mode
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  mode_reg;
  logic [7:0]  clk_sel_reg;
  logic [7:0]  insw_reg;
  logic [7:0]  txbuf_reg;
  logic [7:0]  shift_reg;
  logic        active_reg;
  logic [3:0]  bits_reg;
  logic [6:0]  div_reg;
  logic        sck_reg;
  logic        so_reg;
  logic        tx_cycle_reg;
  twsp_state_t state_reg;
  logic [1:0]  sck_a_sync_reg;
  logic [1:0]  sck_b_sync_reg;
  logic [1:0]  si_a_sync_reg;
  logic [1:0]  si_b_sync_reg;
  logic [1:0]  ss_sync_reg;
  logic        sck_old_reg;

  wire port_enable      = mode_reg[TWSP_BIT_EN];
  wire txrx_mode_sel    = mode_reg[TWSP_BIT_TRMD];
  wire slave_select_use = mode_reg[TWSP_BIT_SSE];
  wire first_bit_sel    = mode_reg[TWSP_BIT_DIR];
  wire clock_polarity_sel = clk_sel_reg[TWSP_BIT_CKP];
  wire data_phase_sel   = clk_sel_reg[TWSP_BIT_DAP];
  wire [2:0] clock_rate_sel = clk_sel_reg[2:0];
  wire pin_route_sel    = insw_reg[TWSP_BIT_ROUTE];
  wire slave_mode       = (clock_rate_sel == TWSP_CKS_SLAVE);

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  wire sel_insw  = (reg_addr == TWSP_ADDR_INSW);
  wire sel_mode  = (reg_addr == TWSP_ADDR_MODE);
  wire sel_clk   = (reg_addr == TWSP_ADDR_CLK);
  wire sel_txbuf = (reg_addr == TWSP_ADDR_TXBUF);
  wire sel_shift = (reg_addr == TWSP_ADDR_SHIFT);

  // Slave transfers gated by select line when enabled
  wire ss_ok     = !(slave_mode && slave_select_use) || !ss_sync_reg[1];
  wire start_tx  = reg_wr && sel_txbuf && port_enable && txrx_mode_sel
                   && ss_ok && !active_reg;
  wire start_rx  = reg_rd && sel_shift && port_enable && !txrx_mode_sel
                   && ss_ok && !active_reg;
  wire start     = start_tx || start_rx;

  assign reg_rdata = sel_insw  ? insw_reg :
                     sel_mode  ? {mode_reg[7:1], active_reg} :
                     sel_clk   ? clk_sel_reg :
                     sel_txbuf ? txbuf_reg :
                     sel_shift ? shift_reg : 8'h00;

  // ----------------------------------------------------------------
  // Pin synchronisers and routing
  // ----------------------------------------------------------------
  // Each pin synchronised on its own; selection only after the second flop
  wire sck_pin = pin_route_sel ? sck_b_sync_reg[1] : sck_a_sync_reg[1];
  wire si_pin  = pin_route_sel ? si_b_sync_reg[1] : si_a_sync_reg[1];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_a_sync_reg <= 2'h0;
      sck_b_sync_reg <= 2'h0;
      si_a_sync_reg  <= 2'h0;
      si_b_sync_reg  <= 2'h0;
      ss_sync_reg    <= 2'h3;
      sck_old_reg    <= 1'b0;
    end else begin
      sck_a_sync_reg <= {sck_a_sync_reg[0], sck_in_a};
      sck_b_sync_reg <= {sck_b_sync_reg[0], sck_in_b};
      si_a_sync_reg  <= {si_a_sync_reg[0], serial_data_in_a};
      si_b_sync_reg  <= {si_b_sync_reg[0], serial_data_in_b};
      ss_sync_reg    <= {ss_sync_reg[0], slave_select_in_n};
      sck_old_reg    <= sck_pin;
    end
  end

  // Transitions of the normalised external clock (idle level removed)
  wire ext_lvl_now  = sck_pin ^ clock_polarity_sel;
  wire ext_lvl_old  = sck_old_reg ^ clock_polarity_sel;
  wire ext_lead     = ext_lvl_old && !ext_lvl_now;
  wire ext_trail    = !ext_lvl_old && ext_lvl_now;

  // ----------------------------------------------------------------
  // Master clock divider: half period = 2^code cycles
  // ----------------------------------------------------------------
  wire [6:0] div_top  = 7'((8'h01 << clock_rate_sel) - 8'h01);
  wire       div_tick = (div_reg == div_top);

  // Edge events common to master and slave
  wire ev_lead  = slave_mode ? ext_lead  : (div_tick && !sck_reg && state_reg != TWSP_IDLE);
  wire ev_trail = slave_mode ? ext_trail : (div_tick && sck_reg);

  // ----------------------------------------------------------------
  // Bit selection helpers
  // ----------------------------------------------------------------
  wire       out_bit  = first_bit_sel ? shift_reg[0] : shift_reg[7];
  wire [7:0] shift_in = first_bit_sel ? {si_pin, shift_reg[7:1]}
                                      : {shift_reg[6:0], si_pin};
  wire [7:0] load_val = start_tx ? reg_wdata : shift_reg;
  wire       load_bit = first_bit_sel ? load_val[0] : load_val[7];
  wire       last_bit = (bits_reg == TWSP_NBITS - 4'h1);

  // ----------------------------------------------------------------
  // Control and shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg     <= TWSP_RST_VAL;
      clk_sel_reg  <= TWSP_RST_VAL;
      insw_reg     <= TWSP_RST_VAL;
      txbuf_reg    <= TWSP_RST_VAL;
      shift_reg    <= TWSP_RST_VAL;
      active_reg   <= 1'b0;
      bits_reg     <= 4'h0;
      div_reg      <= 7'h00;
      sck_reg      <= 1'b0;
      so_reg       <= 1'b0;
      tx_cycle_reg <= 1'b0;
      state_reg    <= TWSP_IDLE;
    end else begin
      if (reg_wr && sel_mode) begin
        mode_reg <= reg_wdata & TWSP_MODE_WMASK;
      end
      if (reg_wr && sel_clk) begin
        clk_sel_reg <= reg_wdata & TWSP_CLK_WMASK;
      end
      if (reg_wr && sel_insw) begin
        insw_reg <= reg_wdata & TWSP_INSW_WMASK;
      end
      if (reg_wr && sel_txbuf) begin
        txbuf_reg <= reg_wdata;
      end
      div_reg <= (state_reg == TWSP_IDLE || div_tick) ? 7'h00 : div_reg + 7'h01;
      if (!port_enable) begin
        active_reg <= 1'b0;
        shift_reg  <= TWSP_RST_VAL;
        state_reg  <= TWSP_IDLE;
        sck_reg    <= 1'b0;
        so_reg     <= 1'b0;
        bits_reg   <= 4'h0;
      end else if (start) begin
        shift_reg    <= load_val;
        active_reg   <= 1'b1;
        bits_reg     <= 4'h0;
        sck_reg      <= 1'b0;
        tx_cycle_reg <= start_tx;
        // Phase 1: first bit out half a cycle before the first edge
        so_reg       <= start_tx && data_phase_sel && load_bit;
        state_reg    <= data_phase_sel ? TWSP_FIRST : TWSP_LEAD;
      end else if (state_reg != TWSP_IDLE) begin
        if (ev_lead) begin
          sck_reg <= 1'b1;
          if (!data_phase_sel) begin
            so_reg <= tx_cycle_reg && out_bit;
          end
          shift_reg <= shift_in;
        end else if (ev_trail) begin
          sck_reg  <= 1'b0;
          bits_reg <= bits_reg + 4'h1;
          if (data_phase_sel && !last_bit) begin
            so_reg <= tx_cycle_reg && out_bit;
          end
          if (last_bit) begin
            active_reg <= 1'b0;
            state_reg  <= TWSP_IDLE;
          end
        end
      end
    end
  end

  // Sampling on lead edge shifts the stored byte; phase 1 samples, then presents the next
  // bit after the shift; phase 0 takes its out bit on the lead edge from the byte before the shift.

  // ----------------------------------------------------------------
  // Received-byte FIFO
  // ----------------------------------------------------------------
  logic done_q_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q_reg <= 1'b0;
    end else begin
      done_q_reg <= port_enable && ev_trail && last_bit && state_reg != TWSP_IDLE;
    end
  end

  twsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (shift_reg),
    .in_valid  (done_q_reg),
    .in_ready  (),
    .out_data  (rx_pop_data),
    .out_valid (rx_pop_valid),
    .out_ready (rx_pop_ready[0])
  );

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign serial_clock_line_o    = sck_reg ^ clock_polarity_sel;
  // Master drives clock only on the alternate pin pair
  assign serial_clock_line_oe_n = !(port_enable && !slave_mode && pin_route_sel);
  assign serial_data_out        = txrx_mode_sel ? so_reg : 1'b0;
  assign pins_port_mode = (mode_reg == TWSP_RST_VAL) && (clk_sel_reg == TWSP_RST_VAL);
endmodule : twsp_top

// *** sim/twsp_chk.sv ***
// Port checker for the three-wire serial port, bound to its top below.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module twsp_chk
  import twsp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        serial_clock_line_o,
  input wire logic        serial_clock_line_oe_n,
  input wire logic        serial_data_out,
  input wire logic        slave_select_in_n,
  input wire logic        pins_port_mode
);
  logic [7:0] mode_q;
  logic [7:0] clk_q;
  logic [7:0] insw_q;
  wire wr_mode = reg_wr && reg_addr == TWSP_ADDR_MODE;
  wire wr_tx   = reg_wr && reg_addr == TWSP_ADDR_TXBUF;
  wire rd_sh   = reg_rd && reg_addr == TWSP_ADDR_SHIFT;
  wire mst_ok  = mode_q[7] && insw_q[TWSP_BIT_ROUTE] && clk_q[2:0] != TWSP_CKS_SLAVE;
  wire sck_act = serial_clock_line_o != clk_q[TWSP_BIT_CKP] || !mode_q[7];
  wire flag_lo = reg_addr != TWSP_ADDR_MODE || !reg_rdata[TWSP_BIT_ACT];
  // ----------------------------------------
  // Register mirror and properties
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= TWSP_RST_VAL;
      clk_q  <= TWSP_RST_VAL;
      insw_q <= TWSP_RST_VAL;
    end else begin
      if (wr_mode) mode_q <= reg_wdata & TWSP_MODE_WMASK;
      if (reg_wr && reg_addr == TWSP_ADDR_CLK) clk_q <= reg_wdata & TWSP_CLK_WMASK;
      if (reg_wr && reg_addr == TWSP_ADDR_INSW) insw_q <= reg_wdata & TWSP_INSW_WMASK;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_so_low; !mode_q[6] && !$past(mode_q[6]) |-> !serial_data_out; endproperty
  a_so_low: assert property (p_so_low) else $error("data out not low");
  property p_rst; $past(!rst_n) |-> pins_port_mode && flag_lo; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_pins; mode_q != 8'h00 && $past(mode_q) != 8'h00 |-> !pins_port_mode; endproperty
  a_pins: assert property (p_pins) else $error("pins free while in use");
  property p_tx; wr_tx && mode_q[7:6] == 2'b11 && mst_ok |-> ##[1:300] sck_act; endproperty
  a_tx: assert property (p_tx) else $error("transfer did not start");
  property p_rx; rd_sh && mode_q[7:6] == 2'b10 && mst_ok |-> ##[1:300] sck_act; endproperty
  a_rx: assert property (p_rx) else $error("reception did not start");
  property p_idle;
    !mode_q[7] && !$past(mode_q[7]) && !$past(mode_q[7], 2)
      |-> serial_clock_line_o == clk_q[TWSP_BIT_CKP];
  endproperty
  a_idle: assert property (p_idle) else $error("clock idle level wrong");
  property p_oe; !serial_clock_line_oe_n |-> mst_ok || $past(mst_ok); endproperty
  a_oe: assert property (p_oe) else $error("clock driven outside master");
  property p_sel;
    wr_tx && mode_q[7:5] == 3'b111 && clk_q[2:0] == TWSP_CKS_SLAVE && slave_select_in_n
      && $past(slave_select_in_n, 2) |=> ##1 flag_lo;
  endproperty
  a_sel: assert property (p_sel) else $error("slave start while deselected");
  property p_off;
    wr_mode && !reg_wdata[7] |=> ##1 flag_lo && (reg_addr != TWSP_ADDR_SHIFT || reg_rdata == 8'h00);
  endproperty
  a_off: assert property (p_off) else $error("disable did not clear");
  c_tx: cover property (wr_tx && mst_ok);
  c_rx: cover property (rd_sh && mst_ok);
  c_sel: cover property (wr_tx && clk_q[2:0] == TWSP_CKS_SLAVE);
endmodule : twsp_chk
bind twsp_top twsp_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .serial_clock_line_o(serial_clock_line_o), .serial_clock_line_oe_n(serial_clock_line_oe_n),
  .serial_data_out(serial_data_out), .slave_select_in_n(slave_select_in_n),
  .pins_port_mode(pins_port_mode));

// *** sim/twsp_peer.sv ***
// Peripheral model on the far side of the link; acts on clock line falls.
// Assumes the port is master on the alternate pins.
`timescale 1ns/1ps
module twsp_peer (
  input  wire logic       clk,
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic       active,
  input  wire logic       lsb_first,
  input  wire logic [7:0] tx_byte,
  output logic            sdi,
  output logic      [7:0] rx_byte
);
  logic       sck_d = 1'b0;
  logic [2:0] cnt = 3'h0;
  wire        fall = sck_d && !sck;
  wire        bit_now = lsb_first ? tx_byte[cnt] : tx_byte[3'h7 - cnt];
  // Released line shows the inverse of the pending bit
  assign sdi = active ? bit_now : !bit_now;
  always_ff @(posedge clk) begin
    sck_d <= sck;
    // Line level changes while released must not count as bits
    if (!active) begin
      cnt <= 3'h0;
    end else if (fall) begin
      cnt <= cnt + 3'h1;
      rx_byte <= lsb_first ? {sdo, rx_byte[7:1]} : {rx_byte[6:0], sdo};
    end
  end
endmodule : twsp_peer

// *** sim/tb_top.sv ***
// Bench: register map, master transfers into the FIFO, receive, slave gate.
// Assumes the peer model on the alternate pins; inputs change at falling edge.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: %0h vs %0h", $time, g, e); end end
module tb_top import twsp_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  rx_pop_ready = 8'h00;
  logic        ssel_n = 1'b1;
  logic        lsb = 1'b0;
  logic [7:0]  peer_tx = 8'h00;
  logic [7:0]  rdata, pop_data, peer_rx, d, r;
  logic        pop_valid, sck, sck_oe_n, sdo, sdi, pins;
  int          failures = 0;
  int          checks_done = 0;
  integer      seed = 32'h6433;
  logic [7:0]  exp_q[$];
  logic [15:0] addrs [6] = '{TWSP_ADDR_INSW, TWSP_ADDR_MODE, TWSP_ADDR_CLK,
                             TWSP_ADDR_TXBUF, TWSP_ADDR_SHIFT, 16'hFF84};
  logic [7:0]  wv [5] = '{8'hFF, 8'h7F, 8'hFF, 8'hA5, 8'h5A};
  logic [7:0]  mk [5] = '{TWSP_INSW_WMASK, TWSP_MODE_WMASK, TWSP_CLK_WMASK, 8'hFF, 8'h00};
  always #10 clk = ~clk;
  twsp_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata), .rx_pop_ready(rx_pop_ready),
    .rx_pop_data(pop_data), .rx_pop_valid(pop_valid), .sck_in_a(1'b0), .sck_in_b(1'b0),
    .serial_clock_line_o(sck), .serial_clock_line_oe_n(sck_oe_n), .serial_data_in_a(1'b0),
    .serial_data_in_b(sdi), .serial_data_out(sdo), .slave_select_in_n(ssel_n),
    .pins_port_mode(pins));
  twsp_peer u_peer (.clk(clk), .sck(sck), .sdo(sdo), .active(!sck_oe_n), .lsb_first(lsb),
    .tx_byte(peer_tx), .sdi(sdi), .rx_byte(peer_rx));
  function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
    return v & m;
  endfunction : masked
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    #5 v = rdata;
    @(negedge clk);
    reg_rd = 1'b0;
  endtask : rd
  task automatic wait_idle();
    int n = 0;
    do begin
      rd(TWSP_ADDR_MODE, r);
      n++;
    end while (r[TWSP_BIT_ACT] && n < 200);
    `CHK(r[TWSP_BIT_ACT], 1'b0)
  endtask : wait_idle
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #(20 * 20000);
    failures++;
    wrap_up();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    `CHK(pins, 1'b1)
    foreach (addrs[i]) begin
      rd(addrs[i], d);
      `CHK(d, TWSP_RST_VAL)
    end
    foreach (wv[i]) begin
      wr(addrs[i], wv[i]);
      rd(addrs[i], d);
      `CHK(d, masked(wv[i], mk[i]))
    end
    `CHK(pins, 1'b0)
    $display("end: registers");
    wr(TWSP_ADDR_CLK, 8'h03);
    for (int i = 0; i < 17; i++) begin
      if (i == 8) begin
        wr(TWSP_ADDR_MODE, 8'h00);
        wr(TWSP_ADDR_CLK, 8'h1B);
      end
      lsb = i[0];
      peer_tx = 8'($random(seed));
      d = (i == 0) ? 8'hFF : 8'($random(seed));
      wr(TWSP_ADDR_MODE, {3'b110, lsb, 4'h0});
      wr(TWSP_ADDR_TXBUF, d);
      rd(TWSP_ADDR_MODE, r);
      `CHK(r[TWSP_BIT_ACT], 1'b1)
      wait_idle();
      `CHK(peer_rx, d)
      rd(TWSP_ADDR_SHIFT, r);
      `CHK(r, peer_tx)
      if (i < 16) exp_q.push_back(peer_tx);
    end
    rx_pop_ready = 8'h01;
    for (int i = 0; i < 16; i++) begin
      `CHK(pop_valid, 1'b1)
      `CHK(pop_data, exp_q[i])
      @(negedge clk);
    end
    `CHK(pop_valid, 1'b0)
    rx_pop_ready = 8'h00;
    $display("end: master transfers");
    peer_tx = 8'($random(seed)) | 8'h01;
    wr(TWSP_ADDR_MODE, 8'h80);
    rd(TWSP_ADDR_SHIFT, d);
    wait_idle();
    rd(TWSP_ADDR_SHIFT, d);
    `CHK(d, peer_tx)
    wr(TWSP_ADDR_MODE, 8'h00);
    rd(TWSP_ADDR_SHIFT, d);
    `CHK(d, 8'h00)
    rd(TWSP_ADDR_MODE, d);
    `CHK(d, 8'h00)
    $display("end: receive");
    wr(TWSP_ADDR_CLK, 8'h07);
    wr(TWSP_ADDR_MODE, 8'hE0);
    wr(TWSP_ADDR_TXBUF, 8'h3C);
    rd(TWSP_ADDR_MODE, d);
    `CHK(d, 8'hE0)
    ssel_n = 1'b0;
    repeat (3) @(negedge clk);
    wr(TWSP_ADDR_TXBUF, 8'h3C);
    rd(TWSP_ADDR_MODE, d);
    `CHK(d, 8'hE1)
    wr(TWSP_ADDR_MODE, 8'h60);
    rd(TWSP_ADDR_MODE, d);
    `CHK(d, 8'h60)
    wr(TWSP_ADDR_MODE, 8'h00);
    $display("end: slave gate");
    wrap_up();
  end
endmodule : tb_top
